// [rtl/tsi_irq_defines.vh]
/*
  constants for the interrupt and test-command block: register indices, field positions,
  reset values and the frame timing count.
  assumes a 125 MHz device clock and registers reached at byte address = 4 * index.
*/
//
// Behaviour
// [R1] reading interrupt status clears its bits; they stay clear until a new event
// [R2] interrupt output asserts only for set, unmasked status with global gate bit 0 one
// [R3] status bits other than frame-sync error set whatever their masks
// [R4] frame-sync error mask at one stops detection and setting of that flag
// [R5] every implemented mask bit resets to one
// [R6] mask bits: pattern detect 5, pattern error 3, selftest 1, injection 0
// [R7] mask bits 4 and 2 read one, bit 7 reads zero; software writes ones
// [R8] generator-run bit 7 written one starts the generator, zero stops it
// [R9] software changes a pattern style only while its engine is stopped
// [R10] checker-run bit 6 written one starts locking, zero stops checking
// [R11] generator rate bits 5-4: 2.048, 4.096, 8.192 Mbit/s or idle
// [R12] software sets generator rate equal to the chosen transmit highway rate
// [R13] one transmit highway at most takes part in generation
// [R14] running generator or checker leaves all other switching untouched
// [R15] checker rate bits 3-2 use the generator encoding, 11 receives nothing
// [R16] software sets checker rate equal to the receive highway under test
// [R17] one checked highway only, chosen by a separate register
// [R18] test command bits 1-0 read as zero
// [R19] global gate zero blocks the interrupt output whatever the masks
// [R20] status: frame-sync 6, pattern detect 5, error 3, selftest 1, injection 0
// [R21] clear-on-read acts after read data returns; later events survive
`ifndef TSI_IRQ_DEFINES_VH
`define TSI_IRQ_DEFINES_VH

`define TSI_ADDR_W            6
`define TSI_IDX_GLOBAL_GATE   4'h6
`define TSI_IDX_IRQ_STATUS    4'h7
`define TSI_IDX_IRQ_MASK      4'h8
`define TSI_IDX_TEST_CMD      4'h9

`define TSI_BIT_GATE          0
`define TSI_BIT_FS_ERR        6
`define TSI_BIT_PAT_DETECT    5
`define TSI_BIT_PAT_ERROR     3
`define TSI_BIT_SELFTEST      1
`define TSI_BIT_INJECT        0

`define TSI_BIT_GEN_RUN       7
`define TSI_BIT_CHK_RUN       6
`define TSI_GEN_RATE_HI       5
`define TSI_GEN_RATE_LO       4
`define TSI_CHK_RATE_HI       3
`define TSI_CHK_RATE_LO       2

`define TSI_MASK_RESET        8'h7f
`define TSI_MASK_RSVD_ONES    8'h14
`define TSI_MASK_WR_BITS      8'h6b
`define TSI_STATUS_BITS       8'h6b
`define TSI_CMD_WR_BITS       8'hfc
`define TSI_CMD_RESET         8'h00
`define TSI_GATE_RESET        1'b0

`define TSI_RATE_2M048        2'h0
`define TSI_RATE_4M096        2'h1
`define TSI_RATE_8M192        2'h2
`define TSI_RATE_IDLE         2'h3

`define TSI_RESP_OKAY         2'h0
`define TSI_RESP_SLVERR       2'h2

`define TSI_CLK_PERIOD_NS     8
`define TSI_FRAME_TIME_NS     125000
`define TSI_FRAME_CYCLES      ((`TSI_FRAME_TIME_NS + `TSI_CLK_PERIOD_NS - 1) / `TSI_CLK_PERIOD_NS)

`endif

// [rtl/sticky_flags.v]
/*
  bank of sticky event flags, one per bit.
  assumes set and clear vectors are synchronous to aclk; set beats clear.
*/
`timescale 1ns/1ps
module sticky_flags #(
  parameter W = 8
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] set,
  input  wire [W-1:0] clr,
  output wire [W-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_flag
      reg flag;
      always @(posedge aclk) begin
        if (!aresetn) begin
          flag <= 1'b0;
        end else if (set[i]) begin
          // an event in the clearing cycle is kept
          flag <= 1'b1;
        end else if (clr[i]) begin
          flag <= 1'b0;
        end
      end
      assign flags[i] = flag;
    end
  endgenerate
endmodule

// [rtl/axil_reg_port.v]
/*
  axi4-lite slave handshake: one write and one read in flight, write address and data
  in either order, registered responses.
  assumes the parent decodes the held addresses combinationally.
*/
`timescale 1ns/1ps
`include "tsi_irq_defines.vh"
module axil_reg_port (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`TSI_ADDR_W-1:0] awaddr,
  input  wire                   awvalid,
  output reg                    awready,
  input  wire [31:0]            wdata,
  input  wire [3:0]             wstrb,
  input  wire                   wvalid,
  output reg                    wready,
  output reg  [1:0]             bresp,
  output reg                    bvalid,
  input  wire                   bready,
  input  wire [`TSI_ADDR_W-1:0] araddr,
  input  wire                   arvalid,
  output reg                    arready,
  output reg  [31:0]            rdata,
  output reg  [1:0]             rresp,
  output reg                    rvalid,
  input  wire                   rready,
  output reg  [`TSI_ADDR_W-1:0] wr_addr,
  output reg  [31:0]            wr_data,
  output reg  [3:0]             wr_strb,
  output wire                   wr_fire,
  input  wire                   wr_err,
  output reg  [`TSI_ADDR_W-1:0] rd_addr,
  output reg                    rd_fire,
  input  wire [31:0]            rd_data,
  input  wire                   rd_err,
  output wire                   rd_done
);
  assign wr_fire = !awready && !wready && !bvalid;
  assign rd_done = rvalid && rready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `TSI_RESP_OKAY;
      wr_addr <= {`TSI_ADDR_W{1'b0}};
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= wr_err ? `TSI_RESP_SLVERR : `TSI_RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rd_fire <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `TSI_RESP_OKAY;
      rd_addr <= {`TSI_ADDR_W{1'b0}};
    end else begin
      rd_fire <= arvalid && arready;
      if (arvalid && arready) begin
        arready <= 1'b0;
        rd_addr <= araddr;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_err ? `TSI_RESP_SLVERR : `TSI_RESP_OKAY;
      end
      if (rd_done) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

// [rtl/tsi_irq_and_test_command.v]
/*
  interrupt status, mask and global gate, frame-sync error detector and the test
  command register of the time-slot interchanger, behind an axi4-lite slave.
  assumes event inputs are synchronous to aclk; the pattern engines, connection store
  and highway datapath sit outside and consume the run, rate and enable outputs.
*/
`timescale 1ns/1ps
`include "tsi_irq_defines.vh"
module tsi_irq_and_test_command #(
  parameter FRAME_CYCLES = `TSI_FRAME_CYCLES
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  input  wire [`TSI_ADDR_W-1:0] awaddr,
  input  wire                   awvalid,
  output wire                   awready,
  input  wire [31:0]            wdata,
  input  wire [3:0]             wstrb,
  input  wire                   wvalid,
  output wire                   wready,
  output wire [1:0]             bresp,
  output wire                   bvalid,
  input  wire                   bready,
  input  wire [`TSI_ADDR_W-1:0] araddr,
  input  wire                   arvalid,
  output wire                   arready,
  output wire [31:0]            rdata,
  output wire [1:0]             rresp,
  output wire                   rvalid,
  input  wire                   rready,
  input  wire                   frame_pulse,
  input  wire                   pattern_lock_flag,
  input  wire                   pattern_error_seen,
  input  wire                   memory_selftest_done,
  input  wire                   error_injection_done,
  output reg                    irq,
  output reg                    generator_run,
  output reg                    checker_run,
  output reg  [1:0]             generator_rate_field,
  output reg  [1:0]             checker_rate_field,
  output reg                    generator_start,
  output reg                    checker_start,
  output reg                    generator_tx_enable,
  output reg                    checker_rx_enable
);
  localparam [15:0] FRAME_LAST = FRAME_CYCLES[15:0] - 16'h0001;

  function reg_hit;
    input [`TSI_ADDR_W-1:0] addr;
    input [3:0]             idx;
    begin
      reg_hit = (addr[1:0] == 2'h0) && (addr[`TSI_ADDR_W-1:2] == idx);
    end
  endfunction

  function mapped;
    input [`TSI_ADDR_W-1:0] addr;
    begin
      mapped = reg_hit(addr, `TSI_IDX_GLOBAL_GATE) || reg_hit(addr, `TSI_IDX_IRQ_STATUS) ||
               reg_hit(addr, `TSI_IDX_IRQ_MASK) || reg_hit(addr, `TSI_IDX_TEST_CMD);
    end
  endfunction

  wire [`TSI_ADDR_W-1:0] wr_addr;
  wire [31:0]            wr_data;
  wire [3:0]             wr_strb;
  wire                   wr_fire;
  wire [`TSI_ADDR_W-1:0] rd_addr;
  wire                   rd_fire;
  wire                   rd_done;
  reg  [31:0]            rd_data;
  wire                   wr_err;
  wire                   rd_err;

  axil_reg_port u_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_fire (wr_fire),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_fire (rd_fire),
    .rd_data (rd_data),
    .rd_err  (rd_err),
    .rd_done (rd_done)
  );

  assign wr_err = !mapped(wr_addr);
  assign rd_err = !mapped(rd_addr);

  // registers hold their 8-bit value in byte lane 0
  wire lane0_wr = wr_fire && wr_strb[0];
  wire wr_gate  = lane0_wr && reg_hit(wr_addr, `TSI_IDX_GLOBAL_GATE);
  wire wr_mask  = lane0_wr && reg_hit(wr_addr, `TSI_IDX_IRQ_MASK);
  wire wr_cmd   = lane0_wr && reg_hit(wr_addr, `TSI_IDX_TEST_CMD);

  reg       global_irq_gate;
  reg [7:0] mask_store;
  wire [7:0] irq_mask = (mask_store & `TSI_MASK_WR_BITS) | `TSI_MASK_RSVD_ONES; // see [R7]
  wire frame_sync_error_mask = mask_store[`TSI_BIT_FS_ERR];

  always @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_gate <= `TSI_GATE_RESET;
      mask_store      <= `TSI_MASK_RESET; // see [R5]
    end else begin
      if (wr_gate) begin
        global_irq_gate <= wr_data[`TSI_BIT_GATE];
      end
      if (wr_mask) begin
        mask_store <= wr_data[7:0] & `TSI_MASK_WR_BITS; // see [R6]
      end
    end
  end

  // frame-sync checker: a pulse off the expected slot or a missing one is an error
  reg [15:0] frame_cnt;
  reg        frame_locked;
  reg        fs_error_event;

  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt      <= 16'h0000;
      frame_locked   <= 1'b0;
      fs_error_event <= 1'b0;
    end else if (frame_sync_error_mask) begin
      // held idle so the first pulse after unmasking only arms the checker
      frame_cnt      <= 16'h0000; // see [R4]
      frame_locked   <= 1'b0;
      fs_error_event <= 1'b0;
    end else if (frame_pulse) begin
      fs_error_event <= frame_locked && (frame_cnt != FRAME_LAST);
      frame_locked   <= 1'b1;
      frame_cnt      <= 16'h0000;
    end else if (frame_locked && frame_cnt == FRAME_LAST) begin
      fs_error_event <= 1'b1;
      frame_cnt      <= 16'h0000;
    end else begin
      fs_error_event <= 1'b0;
      frame_cnt      <= frame_cnt + 16'h0001;
    end
  end

  reg lock_prev;
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev <= 1'b0;
    end else begin
      lock_prev <= pattern_lock_flag;
    end
  end

  reg [7:0] status_set;
  always @* begin
    status_set = 8'h00;
    status_set[`TSI_BIT_FS_ERR]     = fs_error_event && !frame_sync_error_mask; // see [R4]
    status_set[`TSI_BIT_PAT_DETECT] = pattern_lock_flag && !lock_prev; // see [R3] [R20]
    status_set[`TSI_BIT_PAT_ERROR]  = pattern_error_seen; // see [R3]
    status_set[`TSI_BIT_SELFTEST]   = memory_selftest_done;
    status_set[`TSI_BIT_INJECT]     = error_injection_done;
  end

  // snapshot of the bits returned, so only those are cleared
  reg  [7:0] status_snap;
  reg        status_read;
  wire [7:0] irq_status;
  wire [7:0] status_clr = (rd_done && status_read) ? status_snap : 8'h00; // see [R1] [R21]

  sticky_flags #(
    .W (8)
  ) u_status (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (status_set & `TSI_STATUS_BITS),
    .clr     (status_clr),
    .flags   (irq_status)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_snap <= 8'h00;
      status_read <= 1'b0;
    end else if (rd_fire) begin
      status_snap <= irq_status;
      status_read <= reg_hit(rd_addr, `TSI_IDX_IRQ_STATUS);
    end else if (rd_done) begin
      status_read <= 1'b0;
    end
  end

  wire [7:0] test_cmd = {generator_run, checker_run, generator_rate_field,
                         checker_rate_field, 2'b00}; // see [R18]

  always @* begin
    rd_data = 32'h0000_0000;
    if (reg_hit(rd_addr, `TSI_IDX_GLOBAL_GATE)) begin
      rd_data[`TSI_BIT_GATE] = global_irq_gate;
    end else if (reg_hit(rd_addr, `TSI_IDX_IRQ_STATUS)) begin
      rd_data[7:0] = irq_status;
    end else if (reg_hit(rd_addr, `TSI_IDX_IRQ_MASK)) begin
      rd_data[7:0] = irq_mask;
    end else if (reg_hit(rd_addr, `TSI_IDX_TEST_CMD)) begin
      rd_data[7:0] = test_cmd;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= global_irq_gate && |(irq_status & ~irq_mask & `TSI_STATUS_BITS); // see [R2] [R19]
    end
  end

  // style changes are only safe while the engine is stopped; not policed here
  always @(posedge aclk) begin
    if (!aresetn) begin
      generator_run        <= 1'b0;
      checker_run          <= 1'b0;
      generator_rate_field <= `TSI_RATE_2M048;
      checker_rate_field   <= `TSI_RATE_2M048;
      generator_start      <= 1'b0;
      checker_start        <= 1'b0;
      generator_tx_enable  <= 1'b0;
      checker_rx_enable    <= 1'b0;
    end else begin
      generator_start <= wr_cmd && wr_data[`TSI_BIT_GEN_RUN]; // see [R8]
      checker_start   <= wr_cmd && wr_data[`TSI_BIT_CHK_RUN]; // see [R10]
      if (wr_cmd) begin
        generator_run        <= wr_data[`TSI_BIT_GEN_RUN]; // see [R8]
        checker_run          <= wr_data[`TSI_BIT_CHK_RUN]; // see [R10]
        generator_rate_field <= wr_data[`TSI_GEN_RATE_HI:`TSI_GEN_RATE_LO]; // see [R11]
        checker_rate_field   <= wr_data[`TSI_CHK_RATE_HI:`TSI_CHK_RATE_LO]; // see [R15]
      end
      // a single enable each: one highway per engine, chosen outside this block
      generator_tx_enable <= generator_run &&
                             (generator_rate_field != `TSI_RATE_IDLE); // see [R11] [R13] [R14]
      checker_rx_enable   <= checker_run &&
                             (checker_rate_field != `TSI_RATE_IDLE); // see [R15] [R17] [R14]
    end
  end
endmodule

// [verification/tsi_irq_chk_sva.sv]
/*
  concurrent checks for the interrupt and test-command block.
  assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`include "tsi_irq_defines.vh"
module tsi_irq_chk (
  input wire                   aclk,
  input wire                   aresetn,
  input wire [`TSI_ADDR_W-1:0] awaddr,
  input wire                   awvalid,
  input wire                   awready,
  input wire [`TSI_ADDR_W-1:0] araddr,
  input wire                   arvalid,
  input wire                   arready,
  input wire [31:0]            rdata,
  input wire                   rvalid,
  input wire                   rready,
  input wire                   irq,
  input wire                   generator_run,
  input wire                   checker_run,
  input wire [1:0]             generator_rate_field,
  input wire [1:0]             checker_rate_field,
  input wire                   generator_start,
  input wire                   checker_start,
  input wire                   generator_tx_enable,
  input wire                   checker_rx_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // which register the pending read targets: 1 mask, 2 command, 3 status
  reg [1:0] rd_kind;
  reg       mask_wr;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_kind <= 2'h0;
      mask_wr <= 1'b0;
    end else begin
      if (arvalid && arready)
        rd_kind <= (araddr == {`TSI_IDX_IRQ_MASK, 2'b00}) ? 2'h1 :
                   (araddr == {`TSI_IDX_TEST_CMD, 2'b00}) ? 2'h2 :
                   (araddr == {`TSI_IDX_IRQ_STATUS, 2'b00}) ? 2'h3 : 2'h0;
      if (awvalid && awready && awaddr == {`TSI_IDX_IRQ_MASK, 2'b00})
        mask_wr <= 1'b1;
    end
  end
  sequence s_gen_go;
    generator_start ##1 !generator_start ##[0:2] generator_run;
  endsequence
  sequence s_chk_go;
    checker_start ##1 !checker_start ##[0:2] checker_run;
  endsequence
  AST_GEN_START: assert property (generator_start |-> s_gen_go)
    else $error("generator start pulse or run level wrong");
  AST_CHK_START: assert property (checker_start |-> s_chk_go)
    else $error("checker start pulse or run level wrong");
  AST_TX_EN: assert property (generator_tx_enable ==
    $past(generator_run && generator_rate_field != `TSI_RATE_IDLE))
    else $error("transmit enable does not follow run and rate");
  AST_RX_EN: assert property (checker_rx_enable ==
    $past(checker_run && checker_rate_field != `TSI_RATE_IDLE))
    else $error("receive enable does not follow run and rate");
  AST_MASK_RD: assert property (rvalid && rd_kind == 2'h1 |->
    (rdata[7:0] & 8'h94) == `TSI_MASK_RSVD_ONES)
    else $error("mask reserved bits read wrong");
  AST_CMD_RD: assert property (rvalid && rd_kind == 2'h2 |-> rdata[1:0] == 2'h0)
    else $error("command reserved bits not zero");
  AST_STAT_RD: assert property (rvalid && rd_kind == 2'h3 |->
    (rdata[7:0] & ~`TSI_STATUS_BITS) == 8'h00 && rdata[31:8] == 24'h00_0000)
    else $error("status unused bits not zero");
  AST_IRQ_QUIET: assert property (!mask_wr |-> !irq)
    else $error("interrupt raised before any mask write");
  AST_RD_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before it was taken");
endmodule
bind tsi_irq_and_test_command tsi_irq_chk u_chk (.aclk, .aresetn, .awaddr, .awvalid,
  .awready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .irq, .generator_run,
  .checker_run, .generator_rate_field, .checker_rate_field, .generator_start,
  .checker_start, .generator_tx_enable, .checker_rx_enable);

// [verification/tsi_irq_and_test_command_tb_top.sv]
/*
  register-level testbench for the interrupt and test-command block.
  assumes axi4-lite access at byte address 4 * index and a short frame count.
*/
`timescale 1ns/1ps
`include "tsi_irq_defines.vh"
module tsi_irq_and_test_command_tb_top;
  localparam FC = 20;
  localparam [1:0] OK = `TSI_RESP_OKAY;
  localparam [1:0] SE = `TSI_RESP_SLVERR;
  reg        aclk = 1'b0;
  reg        aresetn = 1'b0;
  reg [5:0]  awaddr = 6'h00, araddr = 6'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg [3:0]  wstrb = 4'h0;
  reg        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg        frame_pulse = 1'b0, pattern_lock_flag = 1'b0, pattern_error_seen = 1'b0;
  reg        memory_selftest_done = 1'b0, error_injection_done = 1'b0;
  wire       awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp, generator_rate_field, checker_rate_field;
  wire [31:0] rdata;
  wire       generator_run, checker_run, generator_start, checker_start;
  wire       generator_tx_enable, checker_rx_enable;
  integer    num_errors = 0, comparisons = 0, i;
  reg [7:0]  rv, rv2;
  reg [1:0]  rr;
  reg        slow = 1'b0;
  always #4 aclk = ~aclk;
  tsi_irq_and_test_command #(.FRAME_CYCLES(FC)) u_dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .frame_pulse, .pattern_lock_flag,
    .pattern_error_seen, .memory_selftest_done, .error_injection_done, .irq, .generator_run,
    .checker_run, .generator_rate_field, .checker_rate_field, .generator_start,
    .checker_start, .generator_tx_enable, .checker_rx_enable);
  task give_verdict;
    begin
      if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  // a stuck handshake ends the run instead of hanging it
  task hang;
    begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  endtask
  task wr(input [3:0] idx, input [7:0] d, input [1:0] er);
    integer n;
    reg     done;
    begin
      @(posedge aclk);
      done = 1'b0;
      awaddr <= {idx, 2'b00};
      wdata <= {24'h00_0000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge aclk);
        if (awready === 1'b1) awvalid <= 1'b0;
        if (wready === 1'b1) wvalid <= 1'b0;
        if (bvalid === 1'b1) begin
          done = 1'b1;
          bready <= 1'b0;
          rr = bresp;
        end
      end
      if (!done) hang;
      cmp(rr, er);
    end
  endtask
  task rdx(input [3:0] idx);
    integer n;
    reg     done;
    begin
      @(posedge aclk);
      done = 1'b0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      // slow mode raises rready only once rvalid is seen, so the answer must stand
      rready <= !slow;
      for (n = 0; n < 50 && !done; n = n + 1) begin
        @(posedge aclk);
        if (arready === 1'b1) arvalid <= 1'b0;
        if (rvalid === 1'b1 && rready !== 1'b1) begin
          rready <= 1'b1;
        end else if (rvalid === 1'b1) begin
          done = 1'b1;
          rready <= 1'b0;
          rv = rdata[7:0];
          rr = rresp;
        end
      end
      if (!done) hang;
    end
  endtask
  task rd(input [3:0] idx, input [7:0] ed, input [1:0] er);
    begin
      rdx(idx);
      cmp(rv, ed);
      cmp(rr, er);
    end
  endtask
  task ev(input [2:0] m);
    begin
      {pattern_error_seen, memory_selftest_done, error_injection_done} <= m;
      tick(1);
      {pattern_error_seen, memory_selftest_done, error_injection_done} <= 3'h0;
      tick(1);
    end
  endtask
  task fs(input integer gap);
    begin
      tick(gap - 1);
      frame_pulse <= 1'b1;
      tick(1);
      frame_pulse <= 1'b0;
    end
  endtask
  initial begin
    tick(6);
    aresetn <= 1'b1;
    rd(`TSI_IDX_IRQ_MASK, `TSI_MASK_RESET, OK);
    rd(`TSI_IDX_TEST_CMD, `TSI_CMD_RESET, OK);
    rd(`TSI_IDX_IRQ_STATUS, 8'h00, OK);
    rd(4'h0, 8'h00, SE);
    wr(4'h0, 8'hff, SE);
    // software always writes ones to mask bits 4 and 2
    wr(`TSI_IDX_IRQ_MASK, 8'h14, OK);
    rd(`TSI_IDX_IRQ_MASK, 8'h14, OK);
    wr(`TSI_IDX_IRQ_MASK, 8'hff, OK);
    rd(`TSI_IDX_IRQ_MASK, 8'h7f, OK);
    pattern_lock_flag <= 1'b1;
    ev(3'h7);
    tick(3);
    cmp(irq, 1'b0);
    slow = 1'b1;
    rd(`TSI_IDX_IRQ_STATUS, 8'h2b, OK);
    slow = 1'b0;
    rd(`TSI_IDX_IRQ_STATUS, 8'h00, OK);
    pattern_lock_flag <= 1'b0;
    wr(`TSI_IDX_IRQ_MASK, 8'h54, OK);
    ev(3'h2);
    tick(4);
    cmp(irq, 1'b0);
    wr(`TSI_IDX_GLOBAL_GATE, 8'h01, OK);
    tick(3);
    cmp(irq, 1'b1);
    rd(`TSI_IDX_IRQ_STATUS, 8'h02, OK);
    tick(3);
    cmp(irq, 1'b0);
    wr(`TSI_IDX_IRQ_MASK, 8'h55, OK);
    ev(3'h1);
    tick(4);
    cmp(irq, 1'b0);
    rd(`TSI_IDX_IRQ_STATUS, 8'h01, OK);
    tick(3 * FC);
    rd(`TSI_IDX_IRQ_STATUS, 8'h00, OK);
    wr(`TSI_IDX_IRQ_MASK, 8'h14, OK);
    fs(2);
    repeat (3) fs(FC);
    rd(`TSI_IDX_IRQ_STATUS, 8'h00, OK);
    fs(7);
    tick(3);
    rd(`TSI_IDX_IRQ_STATUS, 8'h40, OK);
    wr(`TSI_IDX_IRQ_MASK, 8'h7f, OK);
    // reserved bits written as ones must still read back as zero
    for (i = 0; i < 4; i = i + 1) begin
      wr(`TSI_IDX_TEST_CMD, {2'b11, i[1:0], ~i[1:0], 2'b11}, OK);
      tick(3);
      cmp(generator_rate_field, i[1:0]);
      cmp(checker_rate_field, {~i[1:0]});
      cmp({generator_tx_enable, checker_rx_enable}, {i != 3, i != 0});
      cmp({generator_run, checker_run}, 2'b11);
      rd(`TSI_IDX_TEST_CMD, {2'b11, i[1:0], ~i[1:0], 2'b00}, OK);
    end
    wr(`TSI_IDX_TEST_CMD, 8'h00, OK);
    tick(3);
    cmp({generator_run, checker_run, generator_tx_enable}, 3'h0);
    wr(`TSI_IDX_TEST_CMD, 8'h80, OK);
    tick(3);
    cmp({generator_run, checker_run, generator_tx_enable}, 3'h5);
    wr(`TSI_IDX_TEST_CMD, 8'h00, OK);
    fork
      rdx(`TSI_IDX_IRQ_STATUS);
      begin
        tick(2);
        ev(3'h4);
      end
    join
    rv2 = rv;
    rdx(`TSI_IDX_IRQ_STATUS);
    cmp({1'b0, rv2[3]} + {1'b0, rv[3]}, 2'h1);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    rd(`TSI_IDX_IRQ_MASK, `TSI_MASK_RESET, OK);
    rd(`TSI_IDX_TEST_CMD, `TSI_CMD_RESET, OK);
    give_verdict;
  end
endmodule
